//--- pkg/mac_sec_pkg.sv
// Constants, types and state layout of the transmit frame security engine
package mac_sec_pkg;

	localparam logic [9:0] ADDR_BEACON_CTRL  = 10'h01A;
	localparam logic [9:0] ADDR_NORMAL_CTRL  = 10'h01B;
	localparam logic [9:0] ADDR_SLOT1_CTRL   = 10'h01C;
	localparam logic [9:0] ADDR_SLOT2_CTRL   = 10'h01D;
	localparam logic [9:0] ADDR_SEND_STATUS  = 10'h024;
	localparam logic [9:0] ADDR_CIPHER_A     = 10'h02C;
	localparam logic [9:0] ADDR_CIPHER_B     = 10'h02D;
	localparam logic [9:0] ADDR_IRQ_FLAGS    = 10'h031;
	localparam logic [9:0] ADDR_IRQ_ENABLES  = 10'h032;
	localparam logic [9:0] ADDR_CIPHER_C     = 10'h037;
	localparam logic [9:0] ADDR_KEY_BASE     = 10'h280;
	localparam logic [9:0] ADDR_FRAME_BASE   = 10'h300;

	localparam int SEC_EN_BIT    = 1;
	localparam int GO_BIT        = 0;
	localparam int RETRY_LSB     = 6;
	localparam int BUSY_FAIL_BIT = 5;
	localparam int NORMAL_FAIL_BIT = 0;
	localparam int NO_TIME_BIT0  = 3;
	localparam int NORMAL_SUITE_LSB = 0;
	localparam int SLOT1_SUITE_LSB  = 0;
	localparam int SLOT2_SUITE_LSB  = 3;
	localparam int BEACON_SUITE_LSB = 4;

	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic [7:0] RCON_FIRST = 8'h01;
	localparam logic [3:0] LAST_ROUND = 4'hA;

	typedef enum logic [1:0] {Q_NORMAL, Q_SLOT1, Q_SLOT2, Q_BEACON} queue_t;

	typedef enum logic [2:0]
	{
		SUITE_NONE, SUITE_CTR, SUITE_CCM128, SUITE_CCM64,
		SUITE_CCM32, SUITE_CBC128, SUITE_CBC64, SUITE_CBC32
	} suite_t;

	typedef enum {ST_IDLE, ST_ROUND, ST_SEND, ST_WAIT} fsm_t;

	typedef struct packed
	{
		logic       done;
		logic       ok;
		logic [1:0] retries;
		logic       busy_fail;
		logic       no_time;
	} tx_result_t;

	typedef struct packed
	{
		fsm_t              fsm;
		queue_t            queue;
		logic              secured;
		logic [3:0]        round;
		logic [7:0]        rcon;
		logic [127:0]      block;
		logic [127:0]      rkey;
		logic [3:0][7:0]   ctrl;
		logic [7:0]        cipher_a;
		logic [7:0]        cipher_b;
		logic [7:0]        cipher_c;
		logic [7:0]        status;
		logic [7:0]        flags;
		logic [7:0]        enables;
		logic [3:0][127:0] keys;
		logic [3:0][127:0] frames;
		logic [7:0]        rd_data;
		logic              rd_valid;
		logic              irq;
		logic              tx_start;
	} state_t;

endpackage

//--- hdl/mac_tx_frame_encryption.sv
// Transmit frame security engine: AES-128 per queue with send status reporting
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE_01] AES-128 cipher engine for MAC frame security
// [RULE_02] Key store holds four 128-bit keys
// [RULE_03] Key slots at 0x280, 0x290, 0x2A0, 0x2B0
// [RULE_04] Second slotted and beacon share one key
// [RULE_05] Per-queue 3-bit suite select field
// [RULE_06] Suite codes: none, CTR, CCM, CBC-MAC
// [RULE_07] Secure enable plus go encrypts then sends
// [RULE_08] Host loads frame before triggering
// [RULE_09] Host loads key and suite before triggering
// [RULE_10] Normal send done sets flag bit 0
// [RULE_11] Normal outcome: 0 success, 1 failed
// [RULE_12] Normal retry count in status bits 7:6
// [RULE_13] Status bit 5 marks channel busy failure
// [RULE_14] Slotted send done sets flag bit 1/2
// [RULE_15] Slotted outcome: 1 success, 0 failed
// [RULE_16] Slotted retry count in own control 7:6
// [RULE_17] Slotted no-time failure flags bits 3/4
// [RULE_18] Interrupt when flag and enable both set
module mac_tx_frame_encryption
	import mac_sec_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [9:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire tx_result_t i_tx_result,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rvalid,
	output logic            o_irq,
	output logic            o_tx_start,
	output queue_t          o_tx_queue,
	output logic            o_tx_secured
);

	////////////////////////////////////////////////////////////////////////
	// Galois field and AES round helpers

	function automatic logic [7:0] xtime(input logic [7:0] a);
		xtime = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
	endfunction

	function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				p = p ^ x;
			x = xtime(x);
		end
		gf_mul = p;
	endfunction

	// Inverse as a^254, then the affine map
	function automatic logic [7:0] sbox(input logic [7:0] a);
		logic [7:0] r;
		logic [7:0] sq;
		logic [7:0] inv;
		r  = 8'h01;
		sq = a;
		for (int i = 1; i < 8; i++)
		begin
			sq = gf_mul(sq, sq);
			r  = gf_mul(r, sq);
		end
		inv  = r;
		sbox = inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]}
			^ {inv[4:0], inv[7:5]} ^ {inv[3:0], inv[7:4]} ^ 8'h63;
	endfunction

	function automatic logic [7:0] get_byte(input logic [127:0] v, input int k);
		get_byte = v[8 * (15 - k) +: 8];
	endfunction

	function automatic logic [31:0] sub_word(input logic [31:0] w);
		sub_word = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
	endfunction

	function automatic logic [127:0] next_key(input logic [127:0] k, input logic [7:0] rc);
		logic [31:0] t;
		logic [31:0] n0;
		logic [31:0] n1;
		logic [31:0] n2;
		logic [31:0] n3;
		t  = sub_word({k[23:0], k[31:24]}) ^ {rc, 24'h000000};
		n0 = k[127:96] ^ t;
		n1 = k[95:64] ^ n0;
		n2 = k[63:32] ^ n1;
		n3 = k[31:0] ^ n2;
		next_key = {n0, n1, n2, n3};
	endfunction

	// SubBytes, ShiftRows and, except in the last round, MixColumns
	function automatic logic [127:0] aes_round(input logic [127:0] s, input logic last);
		logic [127:0] sh;
		logic [7:0]   a0;
		logic [7:0]   a1;
		logic [7:0]   a2;
		logic [7:0]   a3;
		logic [127:0] mx;
		sh = '0;
		mx = '0;
		for (int c = 0; c < 4; c++)
			for (int r = 0; r < 4; r++)
				sh[8 * (15 - (r + 4 * c)) +: 8] = sbox(get_byte(s, r + 4 * ((c + r) % 4)));
		for (int c = 0; c < 4; c++)
		begin
			a0 = get_byte(sh, 4 * c);
			a1 = get_byte(sh, 4 * c + 1);
			a2 = get_byte(sh, 4 * c + 2);
			a3 = get_byte(sh, 4 * c + 3);
			mx[8 * (15 - 4 * c) +: 8]       = xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3;
			mx[8 * (15 - 4 * c - 1) +: 8]   = a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3;
			mx[8 * (15 - 4 * c - 2) +: 8]   = a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3;
			mx[8 * (15 - 4 * c - 3) +: 8]   = xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3);
		end
		aes_round = last ? sh : mx;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register decode helpers

	function automatic logic in_region(input logic [9:0] a, input logic [9:0] base);
		in_region = (a >= base) && (a < base + 10'h040);
	endfunction

	function automatic logic [1:0] region_slot(input logic [9:0] a, input logic [9:0] base);
		logic [9:0] d;
		d = a - base;
		region_slot = d[5:4];
	endfunction

	function automatic logic [1:0] key_slot_of(input queue_t q);
		key_slot_of = (q == Q_BEACON) ? 2'd2 : 2'(q); // RULE_04
	endfunction

	function automatic logic [2:0] suite_of(input queue_t q, input logic [7:0] ca,
		input logic [7:0] cb, input logic [7:0] cc);
		case (q) // RULE_05
			Q_NORMAL: suite_of = ca[NORMAL_SUITE_LSB +: 3];
			Q_SLOT1:  suite_of = cc[SLOT1_SUITE_LSB +: 3];
			Q_SLOT2:  suite_of = cc[SLOT2_SUITE_LSB +: 3];
			default:  suite_of = cb[BEACON_SUITE_LSB +: 3];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	state_t st_r;
	state_t st_nxt;

	always_comb
	begin
		logic [3:0]   pending;
		queue_t       pick;
		logic [1:0]   slot;
		logic [3:0]   off;
		logic [127:0] rk;
		logic [7:0]   done_flags;
		logic [7:0]   rd_val;
		suite_t       suite;
		pending    = '0;
		pick       = Q_NORMAL;
		slot       = '0;
		off        = '0;
		rk         = '0;
		done_flags = '0;
		rd_val     = '0;
		suite      = SUITE_NONE;
		st_nxt     = st_r;
		st_nxt.tx_start = 1'b0;
		st_nxt.rd_valid = i_reg_rd;

		for (int q = 0; q < 4; q++)
			pending[q] = st_r.ctrl[q][GO_BIT];

		// Fixed priority: beacon, first slot, second slot, normal
		if (pending[Q_NORMAL])
			pick = Q_NORMAL;
		if (pending[Q_SLOT2])
			pick = Q_SLOT2;
		if (pending[Q_SLOT1])
			pick = Q_SLOT1;
		if (pending[Q_BEACON])
			pick = Q_BEACON;

		case (st_r.fsm)
			ST_IDLE:
			begin
				if (|pending)
				begin
					suite = suite_t'(suite_of(pick, st_r.cipher_a, st_r.cipher_b, st_r.cipher_c));
					st_nxt.queue       = pick;
					st_nxt.ctrl[pick][GO_BIT] = 1'b0;
					// RULE_07
					st_nxt.secured     = st_r.ctrl[pick][SEC_EN_BIT] && (suite != SUITE_NONE); // RULE_06
					if (st_r.ctrl[pick][SEC_EN_BIT] && (suite != SUITE_NONE))
					begin
						// RULE_01
						st_nxt.rkey  = st_r.keys[key_slot_of(pick)];
						st_nxt.block = st_r.frames[pick] ^ st_r.keys[key_slot_of(pick)];
						st_nxt.round = 4'h1;
						st_nxt.rcon  = RCON_FIRST;
						st_nxt.fsm   = ST_ROUND;
					end
					else
						st_nxt.fsm = ST_SEND;
				end
			end
			ST_ROUND:
			begin
				// RULE_01
				rk = next_key(st_r.rkey, st_r.rcon);
				st_nxt.rkey  = rk;
				st_nxt.block = aes_round(st_r.block, st_r.round == LAST_ROUND) ^ rk;
				st_nxt.rcon  = xtime(st_r.rcon);
				st_nxt.round = st_r.round + 4'h1;
				if (st_r.round == LAST_ROUND)
				begin
					st_nxt.frames[st_r.queue] = aes_round(st_r.block, 1'b1) ^ rk;
					st_nxt.fsm = ST_SEND;
				end
			end
			ST_SEND:
			begin
				// RULE_07
				st_nxt.tx_start = 1'b1;
				st_nxt.fsm      = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (i_tx_result.done)
				begin
					st_nxt.fsm = ST_IDLE;
					case (st_r.queue)
						Q_NORMAL:
						begin
							done_flags[0] = 1'b1; // RULE_10
							st_nxt.status[NORMAL_FAIL_BIT] = !i_tx_result.ok; // RULE_11
							st_nxt.status[RETRY_LSB +: 2]  = i_tx_result.retries; // RULE_12
							st_nxt.status[BUSY_FAIL_BIT]   = !i_tx_result.ok && i_tx_result.busy_fail; // RULE_13
						end
						Q_SLOT1, Q_SLOT2:
						begin
							done_flags[st_r.queue] = 1'b1; // RULE_14
							st_nxt.status[st_r.queue] = i_tx_result.ok; // RULE_15
							st_nxt.ctrl[st_r.queue][RETRY_LSB +: 2] = i_tx_result.retries; // RULE_16
							st_nxt.status[BUSY_FAIL_BIT] = !i_tx_result.ok && i_tx_result.busy_fail; // RULE_13
							st_nxt.status[NO_TIME_BIT0 + int'(st_r.queue) - 1] =
								!i_tx_result.ok && i_tx_result.no_time; // RULE_17
						end
						default:
						begin
						end
					endcase
				end
			end
			default:
				st_nxt.fsm = ST_IDLE;
		endcase

		////////////////////////////////////////////////////////////////////
		// Register reads; flags clear on read, a new event wins

		if (in_region(i_reg_addr, ADDR_KEY_BASE))
		begin
			off    = 4'(i_reg_addr - ADDR_KEY_BASE);
			rd_val = get_byte(st_r.keys[region_slot(i_reg_addr, ADDR_KEY_BASE)], int'(off));
		end
		else if (in_region(i_reg_addr, ADDR_FRAME_BASE))
		begin
			off    = 4'(i_reg_addr - ADDR_FRAME_BASE);
			rd_val = get_byte(st_r.frames[region_slot(i_reg_addr, ADDR_FRAME_BASE)], int'(off));
		end
		else
		begin
			case (i_reg_addr)
				ADDR_BEACON_CTRL: rd_val = st_r.ctrl[Q_BEACON];
				ADDR_NORMAL_CTRL: rd_val = st_r.ctrl[Q_NORMAL];
				ADDR_SLOT1_CTRL:  rd_val = st_r.ctrl[Q_SLOT1];
				ADDR_SLOT2_CTRL:  rd_val = st_r.ctrl[Q_SLOT2];
				ADDR_SEND_STATUS: rd_val = st_r.status;
				ADDR_CIPHER_A:    rd_val = st_r.cipher_a;
				ADDR_CIPHER_B:    rd_val = st_r.cipher_b;
				ADDR_CIPHER_C:    rd_val = st_r.cipher_c;
				ADDR_IRQ_FLAGS:   rd_val = st_r.flags;
				ADDR_IRQ_ENABLES: rd_val = st_r.enables;
				default:          rd_val = REG_RESET;
			endcase
		end
		if (i_reg_rd)
			st_nxt.rd_data = rd_val;
		if (i_reg_rd && (i_reg_addr == ADDR_IRQ_FLAGS))
			st_nxt.flags = done_flags;
		else
			st_nxt.flags = st_r.flags | done_flags;

		////////////////////////////////////////////////////////////////////
		// Register writes

		if (i_reg_wr)
		begin
			if (in_region(i_reg_addr, ADDR_KEY_BASE))
			begin
				// RULE_02 RULE_03
				slot = region_slot(i_reg_addr, ADDR_KEY_BASE);
				off  = 4'(i_reg_addr - ADDR_KEY_BASE);
				st_nxt.keys[slot][8 * (15 - int'(off)) +: 8] = i_reg_wdata;
			end
			else if (in_region(i_reg_addr, ADDR_FRAME_BASE))
			begin
				slot = region_slot(i_reg_addr, ADDR_FRAME_BASE);
				off  = 4'(i_reg_addr - ADDR_FRAME_BASE);
				st_nxt.frames[slot][8 * (15 - int'(off)) +: 8] = i_reg_wdata;
			end
			else
			begin
				case (i_reg_addr)
					ADDR_BEACON_CTRL: st_nxt.ctrl[Q_BEACON] = {6'h00, i_reg_wdata[1:0]};
					ADDR_NORMAL_CTRL: st_nxt.ctrl[Q_NORMAL] = {3'h0, i_reg_wdata[4:0]};
					ADDR_SLOT1_CTRL:  st_nxt.ctrl[Q_SLOT1][5:0] = i_reg_wdata[5:0];
					ADDR_SLOT2_CTRL:  st_nxt.ctrl[Q_SLOT2][5:0] = i_reg_wdata[5:0];
					ADDR_CIPHER_A:    st_nxt.cipher_a = i_reg_wdata;
					ADDR_CIPHER_B:    st_nxt.cipher_b = {1'b0, i_reg_wdata[6:4], 2'b00, i_reg_wdata[1:0]};
					ADDR_CIPHER_C:    st_nxt.cipher_c = i_reg_wdata;
					ADDR_IRQ_ENABLES: st_nxt.enables  = i_reg_wdata;
					default:
					begin
					end
				endcase
			end
		end

		st_nxt.irq = |(st_nxt.flags & st_nxt.enables); // RULE_18
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			st_r <= '{fsm: ST_IDLE, queue: Q_NORMAL, default: '0};
		else
			st_r <= st_nxt;
	end

	assign o_reg_rdata  = st_r.rd_data;
	assign o_reg_rvalid = st_r.rd_valid;
	assign o_irq        = st_r.irq;
	assign o_tx_start   = st_r.tx_start;
	assign o_tx_queue   = st_r.queue;
	assign o_tx_secured = st_r.secured;

endmodule

`default_nettype wire

//--- sim/radio_link_model.sv
// Radio model answering each send request with one outcome pulse
`timescale 1ns/1ps
`default_nettype none
module radio_link_model
	import mac_sec_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_start,
	input  wire logic [3:0] i_delay,
	input  wire tx_result_t i_outcome,
	output tx_result_t      o_result
);
	logic [3:0] cnt_r;
	logic       busy_r;
	logic       done_r;

	// Fields are meaningless outside the pulse, so show their inverse
	assign o_result = done_r ? tx_result_t'({1'b1, i_outcome[4:0]}) : tx_result_t'({1'b0, ~i_outcome[4:0]});

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cnt_r  <= 4'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= busy_r && cnt_r == 4'h0;
			if (i_start)
			begin
				busy_r <= 1'b1;
				cnt_r  <= i_delay;
			end
			else if (busy_r && cnt_r == 4'h0)
				busy_r <= 1'b0;
			else if (busy_r)
				cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule
`default_nettype wire

//--- sim/mac_tx_frame_encryption_chk.sv
// Port assertions for the transmit frame security engine
`timescale 1ns/1ps
`default_nettype none
module mac_tx_frame_encryption_chk
	import mac_sec_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_resetn,
	input wire logic       i_reg_wr,
	input wire logic       i_reg_rd,
	input wire logic [9:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire tx_result_t i_tx_result,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       o_reg_rvalid,
	input wire logic       o_irq,
	input wire logic       o_tx_start,
	input wire queue_t     o_tx_queue,
	input wire logic       o_tx_secured
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	property p_rd_answer; i_reg_rd |=> o_reg_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_no_answer; !i_reg_rd |=> !o_reg_rvalid; endproperty
	a_no_answer: assert property (p_no_answer) else $error("answer without read");
	property p_rdata_hold; !o_reg_rvalid |-> $stable(o_reg_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_unmapped; i_reg_rd && i_reg_addr == 10'h0FF |=> o_reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_start_pulse; o_tx_start |=> !o_tx_start [*3]; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("send request too long");
	property p_queue_hold; o_tx_start |=> $stable(o_tx_queue) && $stable(o_tx_secured); endproperty
	a_queue_hold: assert property (p_queue_hold) else $error("queue changed after send");
	property p_irq_mask; i_reg_wr && i_reg_addr == ADDR_IRQ_ENABLES && i_reg_wdata == 8'h00 |=> !o_irq; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
	property p_flag_clear; i_reg_rd && i_reg_addr == ADDR_IRQ_FLAGS && !i_tx_result.done ##1 !i_tx_result.done |=> !o_irq; endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("interrupt kept after flag read");

	c_secured: cover property (o_tx_start && o_tx_secured);
	c_irq: cover property ($rose(o_irq));
	c_beacon: cover property (o_tx_start && o_tx_queue == Q_BEACON);
endmodule
bind mac_tx_frame_encryption mac_tx_frame_encryption_chk chk (.i_clk(i_clk), .i_resetn(i_resetn),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.i_tx_result(i_tx_result), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_irq(o_irq),
	.o_tx_start(o_tx_start), .o_tx_queue(o_tx_queue), .o_tx_secured(o_tx_secured));
`default_nettype wire

//--- sim/mac_tx_frame_encryption_bench.sv
// Self-checking bench for the transmit frame security engine
`timescale 1ns/1ps
`default_nettype none
module mac_tx_frame_encryption_bench
	import mac_sec_pkg::*;
;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [9:0] reg_addr = 10'h000;
	logic [7:0] reg_wdata = 8'h00;
	tx_result_t outcome = '0;
	tx_result_t result;
	logic [7:0] rdata;
	logic       rvalid;
	logic       irq;
	logic       tx_start;
	queue_t     tx_queue;
	logic       tx_secured;
	int         errors = 0;
	int         tests_run = 0;
	int         cyc = 0;

	// Known-answer ciphertext for the key and block loaded in t_normal
	localparam logic [127:0] AES_KAT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;

	always #2.5 clk = ~clk;

	mac_tx_frame_encryption dut (.i_clk(clk), .i_resetn(resetn), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_tx_result(result), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .o_irq(irq), .o_tx_start(tx_start), .o_tx_queue(tx_queue),
		.o_tx_secured(tx_secured));
	radio_link_model radio (.i_clk(clk), .i_resetn(resetn), .i_start(tx_start), .i_delay(4'h2),
		.i_outcome(outcome), .o_result(result));

	////////////////////////////////////////
	task automatic stop_test();
		if (errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk); #1;
		reg_wr = 1'b0;
		@(posedge clk); #1;
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk); #1;
		reg_rd = 1'b0;
		chk("rvalid", 8'h01, {7'h0, rvalid});
		chk($sformatf("reg %h", a), e, rdata);
		@(posedge clk); #1;
	endtask

	task automatic send(input logic [9:0] c, input tx_result_t r, input queue_t q, input logic s, input int lat);
		int k;
		outcome = r;
		wr(c, 8'h03);
		k = 1;
		while (tx_start !== 1'b1 && k < 40)
		begin
			@(posedge clk); #1;
			k++;
		end
		chk("latency", 8'(lat), 8'(k));
		chk("queue", {6'h0, q}, {6'h0, tx_queue});
		chk("secured", {7'h0, s}, {7'h0, tx_secured});
		repeat (8) @(posedge clk);
		#1;
	endtask

	////////////////////////////////////////
	task automatic t_reset();
		rd(ADDR_IRQ_FLAGS, 8'h00);
		rd(ADDR_IRQ_ENABLES, 8'h00);
		rd(ADDR_SEND_STATUS, 8'h00);
		wr(10'h0FF, 8'h55);
		rd(10'h0FF, 8'h00);
	endtask

	task automatic t_keys();
		for (int s = 0; s < 4; s++)
		begin
			wr(ADDR_KEY_BASE + 10'(16 * s + 15), 8'hA0 + 8'(s));
			rd(ADDR_KEY_BASE + 10'(16 * s + 15), 8'hA0 + 8'(s));
		end
	endtask

	task automatic t_plain();
		wr(ADDR_CIPHER_A, 8'h00);
		send(ADDR_NORMAL_CTRL, 6'b010000, Q_NORMAL, 1'b0, 2);
		rd(ADDR_SEND_STATUS, 8'h00);
		rd(ADDR_IRQ_FLAGS, 8'h01);
	endtask

	task automatic t_normal();
		wr(ADDR_CIPHER_A, 8'h01);
		wr(ADDR_IRQ_ENABLES, 8'h07);
		for (int k = 0; k < 16; k++)
		begin
			wr(ADDR_KEY_BASE + 10'(k), 8'(k));
			wr(ADDR_FRAME_BASE + 10'(k), 8'(8'h11 * k));
		end
		send(ADDR_NORMAL_CTRL, 6'b001010, Q_NORMAL, 1'b1, 12);
		rd(ADDR_SEND_STATUS, 8'hA1);
		for (int k = 0; k < 16; k++)
			rd(ADDR_FRAME_BASE + 10'(k), AES_KAT[8 * (15 - k) +: 8]);
		chk("irq", 8'h01, {7'h0, irq});
		wr(ADDR_IRQ_ENABLES, 8'h00);
		chk("irq", 8'h00, {7'h0, irq});
		wr(ADDR_IRQ_ENABLES, 8'h07);
		rd(ADDR_IRQ_FLAGS, 8'h01);
		rd(ADDR_IRQ_FLAGS, 8'h00);
		chk("irq", 8'h00, {7'h0, irq});
	endtask

	task automatic t_slot1();
		wr(ADDR_CIPHER_C, 8'h0A);
		send(ADDR_SLOT1_CTRL, 6'b010111, Q_SLOT1, 1'b1, 12);
		rd(ADDR_SEND_STATUS, 8'h83);
		rd(ADDR_SLOT1_CTRL, 8'h42);
		rd(ADDR_IRQ_FLAGS, 8'h02);
	endtask

	task automatic t_slot2();
		send(ADDR_SLOT2_CTRL, 6'b001101, Q_SLOT2, 1'b1, 12);
		rd(ADDR_SEND_STATUS, 8'h93);
		rd(ADDR_SLOT2_CTRL, 8'hC2);
		rd(ADDR_IRQ_FLAGS, 8'h04);
	endtask

	task automatic t_beacon();
		wr(ADDR_CIPHER_B, 8'h10);
		send(ADDR_BEACON_CTRL, 6'b010000, Q_BEACON, 1'b1, 12);
		rd(ADDR_IRQ_FLAGS, 8'h00);
		rd(ADDR_SEND_STATUS, 8'h93);
		rd(ADDR_BEACON_CTRL, 8'h02);
	endtask

	////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			errors++;
			stop_test();
		end
	end

	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_keys();
		t_plain();
		t_normal();
		t_slot1();
		t_slot2();
		t_beacon();
		stop_test();
	end
endmodule
`default_nettype wire
